// file: hw/tcc_pkg.sv
/*
 Shared constants for the chained timer with buffered capture/compare.
 Assumes one system clock; mode encodings are 3-bit fields, the channel direction 2-bit, as documented.
*/
package tcc_pkg;
   // ----------------------------------------------------------------
   // Master output selection
   // ----------------------------------------------------------------
   localparam logic [2:0] TCC_MOS_RESET = 3'h0;
   localparam logic [2:0] TCC_MOS_ENABLE = 3'h1;
   localparam logic [2:0] TCC_MOS_UPDATE = 3'h2;
   localparam logic [2:0] TCC_MOS_CMP1 = 3'h4;
   // ----------------------------------------------------------------
   // Trigger input selection and slave modes
   // ----------------------------------------------------------------
   localparam logic [2:0] TCC_TIS_LINE1 = 3'h1;
   localparam logic [2:0] TCC_TIS_PIN1 = 3'h4;
   localparam logic [2:0] TCC_SMS_OFF = 3'h0;
   localparam logic [2:0] TCC_SMS_GATED = 3'h5;
   localparam logic [2:0] TCC_SMS_TRIGGER = 3'h6;
   localparam logic [2:0] TCC_SMS_EXTCLK = 3'h7;
   // ----------------------------------------------------------------
   // Channel direction and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] TCC_DIR_OUTPUT = 2'h0;
   localparam logic [15:0] TCC_COUNT_RESET = 16'h0000;
   localparam logic [15:0] TCC_CCV_RESET = 16'h0000;
   localparam logic [15:0] TCC_PSC_RESET = 16'h0000;
endpackage : tcc_pkg

// file: hw/tcc_edge_sync.sv
/*
 Two-flop synchroniser with a rising-edge pulse on the synchronised level.
 Assumes the input is asynchronous to sys_clk.
*/
`timescale 1ns/10ps
module tcc_edge_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Signal
   input wire logic async,
   output logic level,
   output logic rise
);
   import tcc_pkg::*;
   logic meta;
   logic last;

   // First flop feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         level <= 1'b0;
      end else begin
         meta <= async;
         level <= meta;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         last <= 1'b0;
      end else begin
         last <= level;
      end
   end

   assign rise = level & ~last;
endmodule : tcc_edge_sync

// file: hw/tcc_ccr_buffer.sv
/*
 One capture/compare value: preload and shadow pair with byte-wise access.
 Assumes byte strobes are one-cycle pulses from software on sys_clk.
*/
`timescale 1ns/10ps
module tcc_ccr_buffer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Mode
   input wire logic [1:0] dirSelect,
   input wire logic [15:0] count,
   input wire logic capture,
   input wire logic updateEvent,
   // Byte access
   input wire logic writeHigh,
   input wire logic writeLow,
   input wire logic [7:0] writeData,
   input wire logic readHigh,
   input wire logic readLow,
   output logic [7:0] readHighData,
   output logic [7:0] readLowData,
   // Compare
   output logic [15:0] shadow,
   output logic captured
);
   import tcc_pkg::*;
   logic [15:0] preload;
   logic freeze;
   logic writeBlock;
   logic isOutput;

   assign isOutput = (dirSelect == TCC_DIR_OUTPUT);

   // --------------------------------------------------------------
   // Freeze and write blocking
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         freeze <= 1'b0;
      end else if (isOutput) begin
         freeze <= 1'b0;
      end else if (readHigh) begin
         freeze <= 1'b1;
      end else if (readLow) begin
         freeze <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         writeBlock <= 1'b0;
      end else if (writeLow) begin
         writeBlock <= 1'b0;
      end else if (writeHigh) begin
         writeBlock <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Preload: bus writes land here in output direction only
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         preload <= TCC_CCV_RESET;
      end else if (isOutput) begin
         if (writeHigh) begin
            preload[15:8] <= writeData;
         end
         if (writeLow) begin
            preload[7:0] <= writeData;
         end
      end else if (capture && !freeze && !readHigh) begin
         preload <= count;
      end else if (!capture && !freeze && !readHigh) begin
         preload <= shadow;
      end
   end

   // --------------------------------------------------------------
   // Shadow: compare copy or capture latch
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shadow <= TCC_CCV_RESET;
         captured <= 1'b0;
      end else begin
         captured <= !isOutput && capture;
         if (!isOutput && capture) begin
            shadow <= count;
         end else if (isOutput && !writeBlock && !writeHigh) begin
            shadow <= preload;
         end
      end
   end

   assign readHighData = preload[15:8];
   assign readLowData = preload[7:0];
   // updateEvent kept for future preload-enable; transfer is continuous
   logic unusedUpd;
   assign unusedUpd = updateEvent;
endmodule : tcc_ccr_buffer

// file: hw/tcc_timer.sv
/*
 16-bit timer with master trigger output, slave trigger modes and a
 buffered capture/compare channel 1.
 Assumes control bits are plain ports driven by logic on sys_clk, and
 input_pin1 is an asynchronous pin.
*/
`timescale 1ns/10ps
module tcc_timer #(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control bits
   input wire logic [2:0] master_output_select,
   input wire logic [2:0] trigger_input_select,
   input wire logic [2:0] slave_mode_select,
   input wire logic master_slave_align,
   input wire logic runSet,
   input wire logic runClear,
   input wire logic force_update_bit,
   input wire logic trigger_irq_enable,
   input wire logic triggerFlagClear,
   input wire logic [15:0] prescaleDivide,
   input wire logic [15:0] reloadValue,
   // Counter write
   input wire logic counterWrite,
   input wire logic [15:0] counterWriteData,
   // Trigger links and pin
   input wire logic internal_trigger_line1,
   input wire logic input_pin1,
   output logic trigger_out,
   // Channel 1
   input wire logic [1:0] channel_direction_select,
   input wire logic ccvWriteHigh,
   input wire logic ccvWriteLow,
   input wire logic [7:0] ccvWriteData,
   input wire logic ccvReadHigh,
   input wire logic ccvReadLow,
   output logic [7:0] ccvReadData,
   output logic compare1_reference,
   // Status
   output logic counter_run_bit,
   output logic [15:0] counter_value,
   output logic update_event,
   output logic trigger_flag,
   output logic triggerIrq
);
   import tcc_pkg::*;

   // Elaboration check: the datapath is 16 bits wide throughout
   if (COUNT_WIDTH != 16) begin : g_width_check
      $error("tcc_timer supports a 16-bit counter only");
   end

   // ----------------------------------------------------------------
   // Trigger input
   // ----------------------------------------------------------------
   logic pinLevel;
   logic pinRise;
   logic trigLevel;
   logic trigRise;
   logic trigFall;
   logic trigLast;

   tcc_edge_sync pinSync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async(input_pin1),
      .level(pinLevel),
      .rise(pinRise)
   );

   // The trigger line comes from a timer on this clock: no synchroniser
   always_comb begin
      trigLevel = 1'b0;
      unique case (trigger_input_select)
         TCC_TIS_LINE1: trigLevel = internal_trigger_line1;
         TCC_TIS_PIN1: trigLevel = pinLevel;
         default: trigLevel = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigLast <= 1'b0;
      end else begin
         trigLast <= trigLevel;
      end
   end

   assign trigRise = (trigger_input_select == TCC_TIS_PIN1) ? pinRise
                     : (trigLevel & ~trigLast);
   assign trigFall = ~trigLevel & trigLast;

   // ----------------------------------------------------------------
   // Run bit and effective counter enable
   // ----------------------------------------------------------------
   logic trigStart;
   logic countEnable;
   logic alignedEnable;

   assign trigStart = (slave_mode_select == TCC_SMS_TRIGGER) && trigRise;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         counter_run_bit <= 1'b0;
      end else if (trigStart) begin
         counter_run_bit <= 1'b1;
      end else if (runClear) begin
         counter_run_bit <= 1'b0;
      end else if (runSet) begin
         counter_run_bit <= 1'b1;
      end
   end

   // Gated mode only qualifies the enable, never the clock
   assign countEnable = (counter_run_bit || trigStart)
      && ((slave_mode_select != TCC_SMS_GATED) || trigLevel);

   // Master delays its own prescaler so slaves that see trigger_out one
   // cycle late start on the same tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         alignedEnable <= 1'b0;
      end else begin
         alignedEnable <= countEnable;
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and counter
   // ----------------------------------------------------------------
   logic [15:0] prescale;
   logic psClockEn;
   logic tick;
   logic overflow;

   assign psClockEn = master_slave_align ? alignedEnable : countEnable;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prescale <= TCC_PSC_RESET;
      end else if (force_update_bit) begin
         prescale <= TCC_PSC_RESET;
      end else if (psClockEn) begin
         if (prescale >= prescaleDivide) begin
            prescale <= TCC_PSC_RESET;
         end else begin
            prescale <= prescale + 16'h0001;
         end
      end
   end

   assign tick = (slave_mode_select == TCC_SMS_EXTCLK)
      ? trigRise
      : (psClockEn && (prescale >= prescaleDivide));
   assign overflow = tick && (counter_value >= reloadValue);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         counter_value <= TCC_COUNT_RESET;
      end else if (force_update_bit) begin
         counter_value <= TCC_COUNT_RESET;
      end else if (counterWrite) begin
         counter_value <= counterWriteData;
      end else if (overflow) begin
         counter_value <= TCC_COUNT_RESET;
      end else if (tick) begin
         counter_value <= counter_value + 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         update_event <= 1'b0;
      end else begin
         update_event <= overflow || force_update_bit;
      end
   end

   // ----------------------------------------------------------------
   // Trigger flag
   // ----------------------------------------------------------------
   logic trigEvent;

   assign trigEvent = ((slave_mode_select == TCC_SMS_GATED)
                       && counter_run_bit && (trigRise || trigFall))
      || trigStart
      || ((slave_mode_select == TCC_SMS_EXTCLK) && trigRise);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigger_flag <= 1'b0;
      end else if (trigEvent) begin
         trigger_flag <= 1'b1;
      end else if (triggerFlagClear) begin
         trigger_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         triggerIrq <= 1'b0;
      end else begin
         triggerIrq <= (trigEvent || (trigger_flag && !triggerFlagClear))
            && trigger_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // Channel 1
   // ----------------------------------------------------------------
   logic [15:0] shadow1;
   logic [7:0] highByte;
   logic [7:0] lowByte;
   logic capture1;

   assign capture1 = pinRise;

   tcc_ccr_buffer ccr1 (
      .sys_clk(sys_clk),
      .rst(rst),
      .dirSelect(channel_direction_select),
      .count(counter_value),
      .capture(capture1),
      .updateEvent(update_event),
      .writeHigh(ccvWriteHigh),
      .writeLow(ccvWriteLow),
      .writeData(ccvWriteData),
      .readHigh(ccvReadHigh),
      .readLow(ccvReadLow),
      .readHighData(highByte),
      .readLowData(lowByte),
      .shadow(shadow1),
      .captured()
   );

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ccvReadData <= 8'h00;
      end else if (ccvReadHigh) begin
         ccvReadData <= highByte;
      end else if (ccvReadLow) begin
         ccvReadData <= lowByte;
      end
   end

   // Reference: high while the counter is below the shadow value, in output direction only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         compare1_reference <= 1'b0;
      end else begin
         compare1_reference <= (channel_direction_select == TCC_DIR_OUTPUT)
            && (counter_value < shadow1);
      end
   end

   // ----------------------------------------------------------------
   // Master trigger output
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigger_out <= 1'b0;
      end else if (master_output_select[2]) begin
         trigger_out <= (counter_value < shadow1)
            && (channel_direction_select == TCC_DIR_OUTPUT);
      end else begin
         unique case (master_output_select[1:0])
            TCC_MOS_ENABLE[1:0]: trigger_out <= countEnable;
            TCC_MOS_UPDATE[1:0]: trigger_out <= overflow
               || force_update_bit;
            default: trigger_out <= force_update_bit;
         endcase
      end
   end
endmodule : tcc_timer

// file: tb/tcc_timer_props.sv
/*
 Port assertions for the chained timer: trigger output, slave modes, loads.
 Assumes it is bound to tcc_timer and shares its single clock domain.
*/
`timescale 1ns/10ps
module tcc_timer_props
   import tcc_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Control
   input wire logic [2:0] master_output_select,
   input wire logic [2:0] trigger_input_select,
   input wire logic [2:0] slave_mode_select,
   input wire logic master_slave_align,
   input wire logic force_update_bit,
   input wire logic trigger_irq_enable,
   input wire logic triggerFlagClear,
   input wire logic counterWrite,
   input wire logic [15:0] counterWriteData,
   input wire logic internal_trigger_line1,
   // Status
   input wire logic trigger_out,
   input wire logic counter_run_bit,
   input wire logic [15:0] counter_value,
   input wire logic update_event,
   input wire logic trigger_flag,
   input wire logic triggerIrq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_update_trig: assert property (
      (master_output_select == TCC_MOS_UPDATE
       && $stable(master_output_select)) |-> trigger_out == update_event)
      else $error("trigger out differs from update pulse");
   a_enable_trig: assert property (
      ($rose(counter_run_bit) && master_output_select == TCC_MOS_ENABLE
       && $stable(master_output_select)) |-> ##[0:1] trigger_out)
      else $error("trigger out missed run enable");
   a_force_zero: assert property (
      force_update_bit |=> counter_value == TCC_COUNT_RESET && update_event)
      else $error("force update did not clear counter");
   a_count_load: assert property (
      (counterWrite && !force_update_bit)
      |=> counter_value == $past(counterWriteData))
      else $error("counter load lost");
   a_irq_level: assert property (
      (trigger_flag && trigger_irq_enable && !triggerFlagClear)
      |-> ##[0:1] triggerIrq)
      else $error("irq missing with flag enabled");
   a_flag_hold: assert property (
      (trigger_flag && !triggerFlagClear) |=> trigger_flag)
      else $error("trigger flag dropped without clear");
   a_trig_start: assert property (
      ($rose(internal_trigger_line1) && slave_mode_select == TCC_SMS_TRIGGER
       && trigger_input_select == TCC_TIS_LINE1)
      |-> ##[1:2] (counter_run_bit && trigger_flag))
      else $error("trigger edge did not start counter");
   a_gate_hold: assert property (
      (slave_mode_select == TCC_SMS_GATED && $stable(slave_mode_select)
       && trigger_input_select == TCC_TIS_LINE1 && !internal_trigger_line1
       && !$past(internal_trigger_line1) && !master_slave_align
       && !counterWrite && !force_update_bit) |=> $stable(counter_value))
      else $error("counter moved with gate closed");
endmodule : tcc_timer_props

// file: tb/tcc_peer_model.sv
/*
 Peer timer on the trigger link: drives a trigger line, counts edges.
 Assumes the same sys_clk as the timer under test.
*/
`timescale 1ns/10ps
module tcc_peer_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Link
   input wire logic pulseReq,
   input wire logic levelReq,
   input wire logic trigIn,
   output logic trigOut,
   output logic [15:0] edgeSeen
);
   logic trigInLast;
   // ----------------------------------------------------------------
   // Trigger source and edge counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigOut <= 1'b0;
      end else begin
         trigOut <= pulseReq | levelReq;
      end
   end
   // Slave in external clock mode: one count per rising edge only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         trigInLast <= 1'b0;
         edgeSeen <= 16'h0;
      end else begin
         trigInLast <= trigIn;
         edgeSeen <= edgeSeen + 16'(trigIn & !trigInLast);
      end
   end
endmodule : tcc_peer_model

// file: tb/tcc_timer_tb.sv
/*
 Self-checking bench for tcc_timer with a peer timer on trigger line 1.
 Assumes tcc_pkg, the peer model and the checker are compiled first.
*/
`timescale 1ns/10ps
module tcc_timer_tb;
   import tcc_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, master_slave_align = 1'b0;
   logic [2:0] master_output_select = 3'h0, trigger_input_select = 3'h0;
   logic [2:0] slave_mode_select = 3'h0;
   logic runSet = 1'b0, runClear = 1'b0, force_update_bit = 1'b0;
   logic trigger_irq_enable = 1'b0, triggerFlagClear = 1'b0;
   logic [15:0] prescaleDivide = 16'h0, reloadValue = 16'hffff;
   logic [15:0] counterWriteData = 16'h0, counter_value, edgeSeen, e0;
   logic counterWrite = 1'b0, input_pin1 = 1'b0, ccvWriteHigh = 1'b0;
   logic ccvWriteLow = 1'b0, ccvReadHigh = 1'b0, ccvReadLow = 1'b0;
   logic [1:0] channel_direction_select = 2'h0;
   logic [7:0] ccvWriteData = 8'h0, ccvReadData, rb;
   logic pulseReq = 1'b0, levelReq = 1'b0, internal_trigger_line1;
   logic trigger_out, compare1_reference, counter_run_bit, update_event;
   logic trigger_flag, triggerIrq;
   int err_total = 0, tests_run = 0, ups = 0;
   always #2 sys_clk = ~sys_clk;
   tcc_timer dut_u (.sys_clk(sys_clk), .rst(rst),
      .master_output_select(master_output_select),
      .trigger_input_select(trigger_input_select),
      .slave_mode_select(slave_mode_select),
      .master_slave_align(master_slave_align), .runSet(runSet),
      .runClear(runClear), .force_update_bit(force_update_bit),
      .trigger_irq_enable(trigger_irq_enable),
      .triggerFlagClear(triggerFlagClear), .prescaleDivide(prescaleDivide),
      .reloadValue(reloadValue), .counterWrite(counterWrite),
      .counterWriteData(counterWriteData),
      .internal_trigger_line1(internal_trigger_line1),
      .input_pin1(input_pin1), .trigger_out(trigger_out),
      .channel_direction_select(channel_direction_select),
      .ccvWriteHigh(ccvWriteHigh), .ccvWriteLow(ccvWriteLow),
      .ccvWriteData(ccvWriteData), .ccvReadHigh(ccvReadHigh),
      .ccvReadLow(ccvReadLow), .ccvReadData(ccvReadData),
      .compare1_reference(compare1_reference),
      .counter_run_bit(counter_run_bit), .counter_value(counter_value),
      .update_event(update_event), .trigger_flag(trigger_flag),
      .triggerIrq(triggerIrq));
   tcc_peer_model peer_u (.sys_clk(sys_clk), .rst(rst), .pulseReq(pulseReq),
      .levelReq(levelReq), .trigIn(trigger_out),
      .trigOut(internal_trigger_line1), .edgeSeen(edgeSeen));
   // ----------------------------------------------------------------
   // Access tasks; each ends one idle edge after dropping its strobe, pin three
   // ----------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task ld(input logic [15:0] v);
      counterWriteData = v;
      counterWrite = 1'b1;
      tick(1);
      counterWrite = 1'b0;
      tick(1);
   endtask : ld
   task run(input logic on);
      runSet = on;
      runClear = !on;
      tick(1);
      runSet = 1'b0;
      runClear = 1'b0;
      tick(1);
   endtask : run
   task rd(input logic hi);
      ccvReadHigh = hi;
      ccvReadLow = !hi;
      tick(1);
      ccvReadHigh = 1'b0;
      ccvReadLow = 1'b0;
      rb = ccvReadData;
      tick(1);
   endtask : rd
   task wr(input logic hi, input logic [7:0] d);
      ccvWriteData = d;
      ccvWriteHigh = hi;
      ccvWriteLow = !hi;
      tick(1);
      ccvWriteHigh = 1'b0;
      ccvWriteLow = 1'b0;
      tick(1);
   endtask : wr
   task pin;
      input_pin1 = 1'b1;
      tick(6);
      input_pin1 = 1'b0;
      tick(3);
   endtask : pin
   task end_sim;
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      tick(3);
      rst = 1'b0;
      chk(counter_value === 16'h0 && trigger_out === 1'b0, "reset");
      ld(16'h00e7);
      chk(counter_value === 16'h00e7, "load");
      force_update_bit = 1'b1;
      tick(1);
      force_update_bit = 1'b0;
      chk(counter_value === 16'h0 && update_event === 1'b1, "force");
      ld(16'h0005);
      slave_mode_select = TCC_SMS_EXTCLK;
      trigger_input_select = TCC_TIS_LINE1;
      run(1'b1);
      repeat (3) begin
         pulseReq = 1'b1;
         tick(1);
         pulseReq = 1'b0;
         tick(3);
      end
      chk(counter_value === 16'h0008, "ext clock");
      slave_mode_select = TCC_SMS_GATED;
      tick(4);
      chk(counter_value === 16'h0008, "gate closed");
      levelReq = 1'b1;
      tick(8);
      levelReq = 1'b0;
      tick(4);
      e0 = counter_value;
      tick(4);
      chk(counter_value === e0 && e0 > 16'h8 && e0 < 16'h12, "gated");
      run(1'b0);
      slave_mode_select = TCC_SMS_TRIGGER;
      trigger_irq_enable = 1'b1;
      triggerFlagClear = 1'b1;
      tick(2);
      triggerFlagClear = 1'b0;
      tick(1);
      chk(counter_run_bit === 1'b0 && trigger_flag === 1'b0, "idle");
      pulseReq = 1'b1;
      tick(1);
      pulseReq = 1'b0;
      tick(3);
      chk(counter_run_bit & trigger_flag & triggerIrq, "start");
      trigger_irq_enable = 1'b0;
      tick(2);
      chk(triggerIrq === 1'b0 && counter_run_bit === 1'b1, "mask");
      run(1'b0);
      chk(counter_run_bit === 1'b0, "stop");
      slave_mode_select = TCC_SMS_OFF;
      trigger_input_select = 3'h0;
      master_output_select = TCC_MOS_ENABLE;
      run(1'b1);
      chk(trigger_out === 1'b1, "enable out");
      run(1'b0);
      tick(1);
      chk(trigger_out === 1'b0, "enable out low");
      master_output_select = TCC_MOS_UPDATE;
      reloadValue = 16'h0003;
      e0 = edgeSeen;
      runSet = 1'b1;
      for (int i = 0; i < 48; i++) begin
         tick(1);
         runSet = 1'b0;
         runClear = (i == 40);
         ups += int'(update_event);
      end
      chk(ups > 5 && int'(edgeSeen - e0) == ups, "update link");
      reloadValue = 16'hffff;
      master_output_select = TCC_MOS_ENABLE;
      trigger_input_select = TCC_TIS_PIN1;
      slave_mode_select = TCC_SMS_TRIGGER;
      master_slave_align = 1'b1;
      force_update_bit = 1'b1;
      triggerFlagClear = 1'b1;
      tick(1);
      force_update_bit = 1'b0;
      triggerFlagClear = 1'b0;
      input_pin1 = 1'b1;
      tick(5);
      chk(counter_run_bit & trigger_flag & trigger_out, "pin");
      chk(counter_value === 16'h0002, "aligned start");
      tick(4);
      chk(counter_value === 16'h0006, "aligned count");
      input_pin1 = 1'b0;
      slave_mode_select = TCC_SMS_OFF;
      run(1'b0);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h40);
      rd(1'b1);
      e0[15:8] = rb;
      rd(1'b0);
      e0[7:0] = rb;
      chk(e0 === 16'h0040, "preload");
      ld(16'h0010);
      chk(compare1_reference === 1'b1, "below");
      ld(16'h0050);
      chk(compare1_reference === 1'b0, "above");
      wr(1'b1, 8'hff);
      tick(1);
      chk(compare1_reference === 1'b0, "blocked");
      wr(1'b0, 8'h00);
      tick(1);
      chk(compare1_reference === 1'b1, "released");
      master_output_select = TCC_MOS_CMP1;
      e0 = edgeSeen;
      tick(2);
      chk(trigger_out === 1'b1 && edgeSeen === e0 + 16'h1, "cmp");
      trigger_input_select = 3'h0;
      channel_direction_select = 2'h1;
      ld(16'h1234);
      pin();
      rd(1'b1);
      chk(rb === 8'h12, "capture high");
      ld(16'h5678);
      pin();
      rd(1'b0);
      chk(rb === 8'h34, "frozen low");
      pin();
      rd(1'b1);
      e0[15:8] = rb;
      rd(1'b0);
      e0[7:0] = rb;
      chk(e0 === 16'h5678, "capture");
      ld(16'h9abc);
      pin();
      rd(1'b0);
      chk(rb === 8'hbc, "low only");
      end_sim();
   end
endmodule : tcc_timer_tb
bind tcc_timer tcc_timer_props #(.COUNT_WIDTH(COUNT_WIDTH)) props_u (
   .sys_clk(sys_clk), .rst(rst),
   .master_output_select(master_output_select),
   .trigger_input_select(trigger_input_select),
   .slave_mode_select(slave_mode_select),
   .master_slave_align(master_slave_align),
   .force_update_bit(force_update_bit),
   .trigger_irq_enable(trigger_irq_enable),
   .triggerFlagClear(triggerFlagClear), .counterWrite(counterWrite),
   .counterWriteData(counterWriteData),
   .internal_trigger_line1(internal_trigger_line1),
   .trigger_out(trigger_out), .counter_run_bit(counter_run_bit),
   .counter_value(counter_value), .update_event(update_event),
   .trigger_flag(trigger_flag), .triggerIrq(triggerIrq));
